// ==== logic/exec_pkg.sv ====
// Constants and types shared by the skip, table-read and xor execution unit.
// Assumes one 200 MHz core clock and a synchronous active-high reset.
package exec_pkg;
    // Data path and program memory shape
    localparam int DATA_W = 8; // Data byte width
    localparam int ROM_W = 15; // Program word width
    localparam int HIGH_W = ROM_W - DATA_W; // High part of a program word
    localparam int PAGE_W = 4; // Page number bits
    localparam int PTR_W = 8; // Table pointer bits
    localparam int PROG_AW = PAGE_W + PTR_W; // Program address bits
    localparam logic [PAGE_W-1:0] LAST_PAGE = 4'hf; // Final program page

    // Cycle counts of the documented forms
    localparam int PLAIN_CYCLES = 1; // Sequential execution
    localparam int SKIP_CYCLES = 2; // Skip with dummy cycle
    localparam int TABLE_CYCLES = 2; // Program memory fetch then write

    // Reset values
    localparam logic [DATA_W-1:0] ACC_RST = 8'h00; // Accumulator after reset
    localparam logic [HIGH_W-1:0] HIGH_RST = 7'h00; // High latch after reset
    localparam logic [DATA_W-1:0] BYTE_RST = 8'h00; // Held address and data bytes after reset
    localparam logic [PROG_AW-1:0] ROM_ADDR_RST = 12'h000; // Program address after reset
    localparam logic READY_RST = 1'b1; // Free to take an instruction after reset
    localparam logic FLAG_RST = 1'b0; // Every status flag after reset

    // Instruction selects handed over by the decoder
    typedef enum logic [3:0] {
        op_idle = 4'h0,
        op_nibble_exchange_to_acc = 4'h1,
        op_skip_if_null = 4'h2,
        op_copy_skip_if_null = 4'h3,
        op_bit_skip_if_null = 4'h4,
        op_table_read_current_page = 4'h5,
        op_table_read_last_page = 4'h6,
        op_xor_to_acc = 4'h7,
        op_xor_to_memory = 4'h8,
        op_xor_immediate = 4'h9
    } op_type;

    // Sequencer states
    typedef enum logic [1:0] {
        st_exec = 2'b00,
        st_dummy = 2'b01,
        st_table = 2'b10
    } state_type;
endpackage

// ==== logic/byte_ops_if.sv ====
// Carrier between the sequencer and its byte operation unit.
// Assumes both ends sit in the core clock domain; all signals combinational.
interface byte_ops_if;
    import exec_pkg::*;
    op_type op; // Instruction being executed
    logic [DATA_W-1:0] acc; // Current accumulator
    logic [DATA_W-1:0] operand; // Addressed data byte
    logic [DATA_W-1:0] imm; // Immediate operand
    logic [2:0] bit_sel; // Selected bit index
    logic [DATA_W-1:0] result; // Byte produced by the operation
    logic skip; // Prefetched instruction must be dropped

    // Sequencer drives the operands and reads the answer
    modport seq (output op, output acc, output operand, output imm, output bit_sel, input result, input skip);
    // Operation unit does the reverse
    modport ops (input op, input acc, input operand, input imm, input bit_sel, output result, output skip);
endinterface

// ==== logic/byte_ops.sv ====
// Combinational byte operations: nibble exchange, xor forms, null tests.
// Assumes the sequencer registers everything it takes from here.
module byte_ops (
    byte_ops_if.ops bus
);
    import exec_pkg::*;

    // Result byte and skip decision per instruction
    always_comb begin
        bus.result = bus.acc;
        bus.skip = 1'b0;
        case (bus.op)
            op_nibble_exchange_to_acc: begin
                // Upper nibble to low half, lower nibble to high half
                bus.result = {bus.operand[3:0], bus.operand[7:4]}; // RQ1
            end
            op_skip_if_null: begin
                bus.skip = (bus.operand == 8'h00); // RQ2
            end
            op_copy_skip_if_null: begin
                // Copy always happens, skip only on a null byte
                bus.result = bus.operand; // RQ3
                bus.skip = (bus.operand == 8'h00); // RQ3
            end
            op_bit_skip_if_null: begin
                bus.skip = ~bus.operand[bus.bit_sel]; // RQ4
            end
            op_xor_to_acc, op_xor_to_memory: begin
                bus.result = bus.acc ^ bus.operand; // RQ7 RQ8
            end
            op_xor_immediate: begin
                bus.result = bus.acc ^ bus.imm; // RQ9
            end
            default: begin
                // Accumulator passes through unchanged
                bus.result = bus.acc;
            end
        endcase
    end
endmodule

// ==== logic/skip_table_xor_exec.sv ====
// Execution sequencer for nibble exchange, null skips, table reads and xor.
// Assumes the decoder presents the addressed data byte on mem_data during
// the issue cycle and that program memory answers rom_data combinationally
// in the cycle rom_rd is high.
//
// Functional notes
// RQ1: Exchange nibbles into accumulator, source unchanged
// RQ2: Null byte skips: two cycles, else one
// RQ3: Copy byte to accumulator, skip if null
// RQ4: Zero selected bit skips with dummy cycle
// RQ5: Current page table read fills byte, latch
// RQ6: Last page table read fills byte, latch
// RQ7: Accumulator becomes accumulator xor data byte
// RQ8: Data byte becomes xor, accumulator kept
// RQ9: Accumulator becomes accumulator xor immediate
// RQ10: Xor updates zero flag only
module skip_table_xor_exec (
    input wire logic clock,
    input wire logic srst,
    input wire logic issue,
    input wire exec_pkg::op_type opcode,
    input wire logic [exec_pkg::DATA_W-1:0] mem_addr,
    input wire logic [exec_pkg::DATA_W-1:0] mem_data,
    input wire logic [2:0] bit_sel,
    input wire logic [exec_pkg::DATA_W-1:0] imm,
    input wire logic [exec_pkg::PTR_W-1:0] table_pointer,
    input wire logic [exec_pkg::PAGE_W-1:0] pc_page,
    input wire logic [exec_pkg::ROM_W-1:0] rom_data,
    output logic ready,
    output logic done,
    output logic discard,
    output logic [exec_pkg::DATA_W-1:0] acc,
    output logic mem_we,
    output logic [exec_pkg::DATA_W-1:0] mem_waddr,
    output logic [exec_pkg::DATA_W-1:0] mem_wdata,
    output logic rom_rd,
    output logic [exec_pkg::PROG_AW-1:0] rom_addr,
    output logic [exec_pkg::HIGH_W-1:0] table_high_byte_latch,
    output logic flag_zero,
    output logic flag_carry,
    output logic flag_half_carry,
    output logic flag_overflow,
    output logic flag_power_down,
    output logic flag_time_out
);
    import exec_pkg::*;

    // Sequencer state
    state_type state_r, state_nxt; // Current step
    logic ready_r, ready_nxt; // Accepting an instruction
    logic done_r, done_nxt; // Instruction finished pulse
    logic discard_r, discard_nxt; // Prefetch dropped pulse
    logic [DATA_W-1:0] hold_addr_r, hold_addr_nxt; // Target byte of a table read

    // Data path state
    logic [DATA_W-1:0] acc_r, acc_nxt; // Accumulator
    logic mem_we_r, mem_we_nxt; // Data byte write pulse
    logic [DATA_W-1:0] waddr_r, waddr_nxt; // Data byte write address
    logic [DATA_W-1:0] wdata_r, wdata_nxt; // Data byte write value
    logic rom_rd_r, rom_rd_nxt; // Program memory read strobe
    logic [PROG_AW-1:0] rom_addr_r, rom_addr_nxt; // Program memory address
    logic [HIGH_W-1:0] high_r, high_nxt; // Table high part latch

    // Status flags; only zero ever moves in this unit
    logic zero_r, zero_nxt; // Null result flag
    logic carry_r; // Carry, held
    logic half_r; // Half carry, held
    logic ovf_r; // Overflow, held
    logic pdown_r; // Power down, held
    logic tout_r; // Time out, held

    logic accept; // Instruction taken this cycle
    logic is_xor; // One of the three xor forms

    byte_ops_if ops_bus ();

    // Byte operations live in their own unit
    byte_ops u_ops (
        .bus(ops_bus)
    );

    assign accept = issue & ready_r;
    assign is_xor = (opcode == op_xor_to_acc) || (opcode == op_xor_to_memory) || (opcode == op_xor_immediate);

    // Operands to the operation unit
    always_comb begin
        ops_bus.op = accept ? opcode : op_idle;
        ops_bus.acc = acc_r;
        ops_bus.operand = mem_data;
        ops_bus.imm = imm;
        ops_bus.bit_sel = bit_sel;
    end

    // Next values of sequencer and data path
    always_comb begin
        state_nxt = state_r;
        ready_nxt = ready_r;
        done_nxt = 1'b0;
        discard_nxt = 1'b0;
        hold_addr_nxt = hold_addr_r;
        acc_nxt = acc_r;
        mem_we_nxt = 1'b0;
        waddr_nxt = waddr_r;
        wdata_nxt = wdata_r;
        rom_rd_nxt = 1'b0;
        rom_addr_nxt = rom_addr_r;
        high_nxt = high_r;
        zero_nxt = zero_r;
        case (state_r)
            st_exec: begin
                if (accept) begin
                    done_nxt = 1'b1;
                    // Accumulator writers take the unit's result
                    if (opcode == op_nibble_exchange_to_acc || opcode == op_copy_skip_if_null
                        || opcode == op_xor_to_acc || opcode == op_xor_immediate) begin
                        acc_nxt = ops_bus.result; // RQ1 RQ3 RQ7 RQ9
                    end
                    // Only the memory xor writes back; accumulator untouched
                    if (opcode == op_xor_to_memory) begin
                        mem_we_nxt = 1'b1; // RQ8
                        waddr_nxt = mem_addr;
                        wdata_nxt = ops_bus.result; // RQ8
                    end
                    // Zero flag from the 8-bit xor result, others held
                    if (is_xor) begin
                        zero_nxt = (ops_bus.result == 8'h00); // RQ10
                    end
                    if (ops_bus.skip) begin
                        // Drop the prefetch, spend one dummy cycle
                        discard_nxt = 1'b1; // RQ2 RQ3 RQ4
                        ready_nxt = 1'b0;
                        state_nxt = st_dummy;
                    end
                    if (opcode == op_table_read_current_page) begin
                        // Page of the running code, offset from the pointer
                        rom_rd_nxt = 1'b1; // RQ5
                        rom_addr_nxt = {pc_page, table_pointer}; // RQ5
                        hold_addr_nxt = mem_addr;
                        done_nxt = 1'b0;
                        ready_nxt = 1'b0;
                        state_nxt = st_table;
                    end else if (opcode == op_table_read_last_page) begin
                        // Fixed final page regardless of where code runs
                        rom_rd_nxt = 1'b1; // RQ6
                        rom_addr_nxt = {LAST_PAGE, table_pointer}; // RQ6
                        hold_addr_nxt = mem_addr;
                        done_nxt = 1'b0;
                        ready_nxt = 1'b0;
                        state_nxt = st_table;
                    end
                end
            end
            st_dummy: begin
                // Dummy cycle over, next real fetch may issue
                ready_nxt = 1'b1; // RQ2 RQ4
                state_nxt = st_exec;
            end
            st_table: begin
                // Low byte to the data byte, high part to the latch
                mem_we_nxt = 1'b1; // RQ5 RQ6
                waddr_nxt = hold_addr_r;
                wdata_nxt = rom_data[DATA_W-1:0]; // RQ5 RQ6
                high_nxt = rom_data[ROM_W-1:DATA_W]; // RQ5 RQ6
                done_nxt = 1'b1;
                ready_nxt = 1'b1;
                state_nxt = st_exec;
            end
            default: begin
                // Unreachable code recovers to the idle step
                ready_nxt = 1'b1;
                state_nxt = st_exec;
            end
        endcase
    end

    // Register everything; flags other than zero are loaded only at reset
    always_ff @(posedge clock) begin
        if (srst) begin
            state_r <= st_exec;
            ready_r <= READY_RST;
            done_r <= 1'b0;
            discard_r <= 1'b0;
            hold_addr_r <= BYTE_RST;
            acc_r <= ACC_RST;
            mem_we_r <= 1'b0;
            waddr_r <= BYTE_RST;
            wdata_r <= BYTE_RST;
            rom_rd_r <= 1'b0;
            rom_addr_r <= ROM_ADDR_RST;
            high_r <= HIGH_RST;
            zero_r <= FLAG_RST;
            carry_r <= FLAG_RST;
            half_r <= FLAG_RST;
            ovf_r <= FLAG_RST;
            pdown_r <= FLAG_RST;
            tout_r <= FLAG_RST;
        end else begin
            state_r <= state_nxt;
            ready_r <= ready_nxt;
            done_r <= done_nxt;
            discard_r <= discard_nxt;
            hold_addr_r <= hold_addr_nxt;
            acc_r <= acc_nxt;
            mem_we_r <= mem_we_nxt;
            waddr_r <= waddr_nxt;
            wdata_r <= wdata_nxt;
            rom_rd_r <= rom_rd_nxt;
            rom_addr_r <= rom_addr_nxt;
            high_r <= high_nxt;
            zero_r <= zero_nxt;
        end
    end

    // Outputs straight from flip-flops
    assign ready = ready_r;
    assign done = done_r;
    assign discard = discard_r;
    assign acc = acc_r;
    assign mem_we = mem_we_r;
    assign mem_waddr = waddr_r;
    assign mem_wdata = wdata_r;
    assign rom_rd = rom_rd_r;
    assign rom_addr = rom_addr_r;
    assign table_high_byte_latch = high_r;
    assign flag_zero = zero_r;
    assign flag_carry = carry_r;
    assign flag_half_carry = half_r;
    assign flag_overflow = ovf_r;
    assign flag_power_down = pdown_r;
    assign flag_time_out = tout_r;

    // Checks on the documented behaviour
    sequence skip_dummy_s;
        discard_r && !ready_r ##1 ready_r && !discard_r;
    endsequence

    sequence no_skip_s;
        !discard_r && ready_r;
    endsequence

    sequence table_fetch_s;
        rom_rd_r && !ready_r && !mem_we_r;
    endsequence

    nibble_exchange_a: assert property (@(posedge clock) disable iff (srst) // RQ1
        accept && opcode == op_nibble_exchange_to_acc |=>
        {acc_r[3:0], acc_r[7:4]} == $past(mem_data) && !mem_we_r && ready_r)
        else $error("nibble exchange result wrong");

    null_skip_a: assert property (@(posedge clock) disable iff (srst) // RQ2
        accept && opcode == op_skip_if_null && mem_data == 8'h00 |=> skip_dummy_s)
        else $error("null skip did not take two cycles");

    nonnull_pass_a: assert property (@(posedge clock) disable iff (srst) // RQ2
        accept && opcode == op_skip_if_null && mem_data != 8'h00 |=> no_skip_s)
        else $error("non null byte caused a skip");

    copy_skip_a: assert property (@(posedge clock) disable iff (srst) // RQ3
        accept && opcode == op_copy_skip_if_null |=>
        acc_r == $past(mem_data) && discard_r == ($past(mem_data) == 8'h00))
        else $error("copy and skip wrong");

    bit_skip_a: assert property (@(posedge clock) disable iff (srst) // RQ4
        accept && opcode == op_bit_skip_if_null && !mem_data[bit_sel] |=> skip_dummy_s)
        else $error("zero bit did not skip");

    current_table_a: assert property (@(posedge clock) disable iff (srst) // RQ5
        accept && opcode == op_table_read_current_page |=>
        table_fetch_s and rom_addr_r == {$past(pc_page), $past(table_pointer)} ##1
        mem_we_r && {table_high_byte_latch, wdata_r} == $past(rom_data))
        else $error("current page table read wrong");

    last_table_a: assert property (@(posedge clock) disable iff (srst) // RQ6
        accept && opcode == op_table_read_last_page |=>
        table_fetch_s and rom_addr_r[11:8] == 4'hf && rom_addr_r[7:0] == $past(table_pointer) ##1
        mem_we_r && waddr_r == $past(mem_addr, 2) && {table_high_byte_latch, wdata_r} == $past(rom_data))
        else $error("last page table read wrong");

    xor_acc_a: assert property (@(posedge clock) disable iff (srst) // RQ7
        accept && opcode == op_xor_to_acc |=> acc_r == ($past(acc_r) ^ $past(mem_data)) && !mem_we_r)
        else $error("accumulator xor wrong");

    xor_memory_a: assert property (@(posedge clock) disable iff (srst) // RQ8
        accept && opcode == op_xor_to_memory |=>
        mem_we_r && wdata_r == ($past(acc_r) ^ $past(mem_data)) && $stable(acc_r))
        else $error("memory xor wrong");

    xor_imm_a: assert property (@(posedge clock) disable iff (srst) // RQ9
        accept && opcode == op_xor_immediate |=> acc_r == ($past(acc_r) ^ $past(imm)))
        else $error("immediate xor wrong");

    xor_flags_a: assert property (@(posedge clock) disable iff (srst) // RQ10
        accept && is_xor |=> flag_zero == (($past(opcode) == op_xor_immediate ?
        $past(acc_r) ^ $past(imm) : $past(acc_r) ^ $past(mem_data)) == 8'h00)
        && $stable(flag_carry) && $stable(flag_half_carry) && $stable(flag_overflow)
        && $stable(flag_power_down) && $stable(flag_time_out))
        else $error("xor flag update wrong");

    bit_pass_a: assert property (@(posedge clock) disable iff (srst) // RQ4
        accept && opcode == op_bit_skip_if_null && mem_data[bit_sel] |=> no_skip_s)
        else $error("set bit caused a skip");

    // An offer held into the dummy cycle must leave no trace
    dummy_refuse_a: assert property (@(posedge clock) disable iff (srst) // RQ2
        issue && state_r == st_dummy |=> !done_r && !discard_r && !mem_we_r && $stable(acc_r))
        else $error("offer taken during dummy cycle");
endmodule

// ==== test/skip_table_xor_exec_tb.sv ====
// Self-checking bench for the skip, table-read and xor execution unit.
// Assumes a combinational program memory that the bench plays in the rom_rd cycle.
module skip_table_xor_exec_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import exec_pkg::*;

    // Ordinary cases: inputs beside expected cycle-1 outputs
    typedef struct {
        op_type op;
        logic [7:0] data;
        logic [2:0] bsel;
        logic [7:0] immv;
        logic [7:0] eacc;
        logic edisc;
        logic ewe;
        logic [7:0] ewdata;
        logic ez;
    } row_type;

    logic clock; // Core clock
    logic srst; // Synchronous reset
    logic issue; // Instruction offer
    op_type opcode; // Instruction select
    logic [7:0] mem_addr; // Addressed byte
    logic [7:0] mem_data; // Its current value
    logic [2:0] bit_sel; // Bit index
    logic [7:0] imm; // Immediate operand
    logic [7:0] table_pointer; // Table pointer
    logic [3:0] pc_page; // Running page
    logic [14:0] rom_data; // Program word
    logic ready, done, discard, mem_we, rom_rd;
    logic [7:0] acc, mem_waddr, mem_wdata;
    logic [11:0] rom_addr;
    logic [6:0] table_high_byte_latch;
    logic flag_zero, flag_carry, flag_half_carry, flag_overflow, flag_power_down, flag_time_out;
    int n_fail; // Mismatches
    int n_compared; // Comparisons
    int cycles = 0; // Run length guard
    row_type rows [14]; // Case table
    logic [3:0] epage; // Expected page of a table read

    skip_table_xor_exec u_skip_table_xor_exec (.clock(clock), .srst(srst), .issue(issue), .opcode(opcode),
        .mem_addr(mem_addr), .mem_data(mem_data), .bit_sel(bit_sel), .imm(imm), .table_pointer(table_pointer),
        .pc_page(pc_page), .rom_data(rom_data), .ready(ready), .done(done), .discard(discard), .acc(acc),
        .mem_we(mem_we), .mem_waddr(mem_waddr), .mem_wdata(mem_wdata), .rom_rd(rom_rd), .rom_addr(rom_addr),
        .table_high_byte_latch(table_high_byte_latch), .flag_zero(flag_zero), .flag_carry(flag_carry),
        .flag_half_carry(flag_half_carry), .flag_overflow(flag_overflow), .flag_power_down(flag_power_down),
        .flag_time_out(flag_time_out));

    // 200 MHz clock
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // Hang guard: whole run is about 80 cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 2000) begin
            n_fail++;
            finish_test();
        end
    end

    // One comparison, four-state exact
    task automatic chk(input string name, input logic [14:0] exp, input logic [14:0] got);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Counts then verdict
    task finish_test;
        $display("Comparisons %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Offer at a falling edge; returns in cycle 1 with issue still high
    task automatic offer(input op_type o, input logic [7:0] d, input logic [2:0] b, input logic [7:0] x,
                         input logic [7:0] a);
        @(negedge clock);
        issue = 1'b1;
        opcode = o;
        mem_data = d;
        bit_sel = b;
        imm = x;
        mem_addr = a;
        @(negedge clock);
    endtask

    // Accumulator and zero flag against expectation; status flags other than zero never move
    task automatic chk_idle(input logic [7:0] eacc, input logic ez);
        chk("acc", eacc, acc);
        chk("flag_zero", ez, flag_zero);
        chk("other_flags", 0, {flag_carry, flag_half_carry, flag_overflow, flag_power_down, flag_time_out});
    endtask

    initial begin
        srst = 1'b1;
        issue = 1'b0;
        opcode = op_idle;
        mem_addr = 8'h00;
        mem_data = 8'h00;
        bit_sel = 3'h0;
        imm = 8'h00;
        table_pointer = 8'h00;
        pc_page = 4'h0;
        rom_data = 15'h7fff;
        n_fail = 0;
        n_compared = 0;
        // Chained: each row starts from the previous accumulator and zero flag
        rows = '{
            '{op_xor_immediate, 8'h00, 3'h0, 8'ha5, 8'ha5, 1'b0, 1'b0, 8'h00, 1'b0},
            '{op_nibble_exchange_to_acc, 8'h3c, 3'h0, 8'h00, 8'hc3, 1'b0, 1'b0, 8'h00, 1'b0},
            '{op_xor_to_acc, 8'hc3, 3'h0, 8'h00, 8'h00, 1'b0, 1'b0, 8'h00, 1'b1},
            '{op_xor_to_memory, 8'h5a, 3'h0, 8'h00, 8'h00, 1'b0, 1'b1, 8'h5a, 1'b0},
            '{op_skip_if_null, 8'h00, 3'h0, 8'h00, 8'h00, 1'b1, 1'b0, 8'h00, 1'b0},
            '{op_skip_if_null, 8'h01, 3'h0, 8'h00, 8'h00, 1'b0, 1'b0, 8'h00, 1'b0},
            '{op_xor_immediate, 8'h00, 3'h0, 8'h18, 8'h18, 1'b0, 1'b0, 8'h00, 1'b0},
            '{op_copy_skip_if_null, 8'h81, 3'h0, 8'h00, 8'h81, 1'b0, 1'b0, 8'h00, 1'b0},
            '{op_bit_skip_if_null, 8'hfe, 3'h0, 8'h00, 8'h81, 1'b1, 1'b0, 8'h00, 1'b0},
            '{op_bit_skip_if_null, 8'h80, 3'h7, 8'h00, 8'h81, 1'b0, 1'b0, 8'h00, 1'b0},
            '{op_xor_to_memory, 8'h81, 3'h0, 8'h00, 8'h81, 1'b0, 1'b1, 8'h00, 1'b1},
            '{op_copy_skip_if_null, 8'h00, 3'h0, 8'h00, 8'h00, 1'b1, 1'b0, 8'h00, 1'b1},
            '{op_xor_immediate, 8'h00, 3'h0, 8'hff, 8'hff, 1'b0, 1'b0, 8'h00, 1'b0},
            '{op_idle, 8'h00, 3'h0, 8'h00, 8'hff, 1'b0, 1'b0, 8'h00, 1'b0}
        };
        repeat (20) @(negedge clock);
        srst = 1'b0;
        chk("ready_rst", 1, ready);
        chk("latch_rst", 0, table_high_byte_latch);
        chk_idle(8'h00, 1'b0);
        for (int i = 0; i < 14; i++) begin
            offer(rows[i].op, rows[i].data, rows[i].bsel, rows[i].immv, 8'h10 + 8'(i));
            issue = 1'b0;
            mem_data = ~rows[i].data; // Byte no longer qualified
            chk("done", 1, done);
            chk("discard", rows[i].edisc, discard);
            chk("ready", !rows[i].edisc, ready);
            chk("mem_we", rows[i].ewe, mem_we);
            if (rows[i].ewe) begin
                chk("mem_waddr", 8'h10 + 8'(i), mem_waddr);
                chk("mem_wdata", rows[i].ewdata, mem_wdata);
            end
            chk_idle(rows[i].eacc, rows[i].ez);
            @(negedge clock);
            chk("done_pulse", 0, done);
            chk("discard_pulse", 0, discard);
            chk("ready_again", 1, ready);
        end
        // Offer held into the dummy cycle must be refused
        offer(op_skip_if_null, 8'h00, 3'h0, 8'h00, 8'h30);
        opcode = op_xor_immediate;
        imm = 8'h0f;
        chk("ready_dummy", 0, ready);
        @(negedge clock);
        issue = 1'b0;
        chk("done_refused", 0, done);
        chk_idle(8'hff, 1'b0);
        // Back-to-back immediate xors
        offer(op_xor_immediate, 8'h00, 3'h0, 8'h01, 8'h31);
        imm = 8'h02;
        chk_idle(8'hfe, 1'b0);
        @(negedge clock);
        issue = 1'b0;
        chk("done_b2b", 1, done);
        chk_idle(8'hfc, 1'b0);
        offer(op_xor_immediate, 8'h00, 3'h0, 8'hfc, 8'h32);
        issue = 1'b0;
        chk_idle(8'h00, 1'b1);
        // Both table reads; zero flag and accumulator must stay
        for (int k = 0; k < 2; k++) begin
            pc_page = 4'h3;
            table_pointer = 8'h40 + 8'(k);
            epage = (k == 1) ? LAST_PAGE : 4'h3;
            offer(k == 1 ? op_table_read_last_page : op_table_read_current_page, 8'h00, 3'h0, 8'h00, 8'h20 + 8'(k));
            issue = 1'b0;
            chk("rom_rd", 1, rom_rd);
            chk("rom_addr", {epage, 8'h40 + 8'(k)}, rom_addr);
            chk("ready_tab", 0, ready);
            rom_data = {7'h2b + 7'(k), 8'hc4 + 8'(k)};
            @(negedge clock);
            rom_data = ~rom_data; // Word only valid in the read cycle
            chk("mem_we_tab", 1, mem_we);
            chk("mem_waddr_tab", 8'h20 + 8'(k), mem_waddr);
            chk("mem_wdata_tab", 8'hc4 + 8'(k), mem_wdata);
            chk("latch_tab", 7'h2b + 7'(k), table_high_byte_latch);
            chk("done_tab", 1, done);
            chk_idle(8'h00, 1'b1);
        end
        // Mid-run reset, then an immediate first offer
        @(negedge clock);
        srst = 1'b1;
        @(negedge clock);
        srst = 1'b0;
        chk("latch_rst2", 0, table_high_byte_latch);
        chk("ready_rst2", 1, ready);
        chk("pulses_rst2", 0, {done, discard, mem_we, rom_rd});
        chk_idle(8'h00, 1'b0);
        offer(op_xor_immediate, 8'h00, 3'h0, 8'h33, 8'h00);
        issue = 1'b0;
        chk_idle(8'h33, 1'b0);
        finish_test();
    end
endmodule
